// ===== design/pgcb_pkg.sv
// Constants for the global event configuration bank.
// Assumes a 25 MHz system clock; all timeouts are whole milliseconds.
package pgcb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] GLOBAL_EVENT_CONFIG = 8'h17;
  localparam logic [7:0] GLOBAL_EVENT_RESET  = 8'h80;
  localparam int IRQ_OUTPUT_ENABLE_BIT       = 7;
  localparam int WIDE_ACCESS_SELECT_BIT      = 5;
  localparam int MULTI_LEVEL_PRIORITY_BIT    = 4;
  localparam int CLASS_CHANGE_ONLY_BIT       = 3;
  localparam int DETECT_CHANGE_ONLY_BIT      = 2;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int CHANNELS      = 8;
  localparam int HALF_CHANNELS = 4;
  localparam int RESULT_W      = 4;
  localparam int MS_W          = 10;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS    = 1000000;
  localparam int TICK_CYCLES       = TICK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [MS_W-1:0] FOUR_PAIR_EXTRA_MS = 10'h006;
  localparam logic [MS_W-1:0] DROPOUT_SEL0_MS    = 10'h168;
  localparam logic [MS_W-1:0] DROPOUT_SEL1_MS    = 10'h05a;
  localparam logic [MS_W-1:0] DROPOUT_SEL2_MS    = 10'h0b4;
  localparam logic [MS_W-1:0] DROPOUT_SEL3_MS    = 10'h2d0;
  localparam logic [MS_W-1:0] MS_COUNT_MAX       = 10'h3ff;

endpackage

// ===== design/pgcb_config_bank.sv
// Global event configuration register of an eight-channel PSE with its
// interrupt gating, event flag policy and power status fault clearing.
// Assumes the serial front end decodes command code and half select, and
// that all channel inputs come from logic on sys_clk.
//
// How it works
// - A limit, overload, dropout or startup fault clears both power flags.
// - Current-limit fault only after the programmed time has fully elapsed.
// - Four-pair overload cut waits the programmed time plus six ms.
// - Command 17h reads and writes one data byte of configuration.
// - Bit 7 resets high; low masks the pending interrupt of the half that copy governs.
// - Interrupt enable never touches event flag capture.
// - Bit 5 high selects sixteen-bit access on the even address.
// - Bit 5 low gives eight-bit access as two four-channel halves.
// - Bit 5 in the channel 1-4 copy alone switches the device.
// - Bit 4 selects three-bit or one-bit shutdown priority.
// - Bit 3 high sets class flag only when the class result changes.
// - Bit 2 high sets detect flag only when the detect result changes.
// - Dropout select 00/01/10/11 gives 360/90/180/720 ms.
// - Dropout counter stops at zero and never wraps.
`timescale 1ns/100ps

module pgcb_config_bank #(
  parameter int unsigned TICK_CYCLES = pgcb_pkg::TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_cmd,
  input  wire logic        reg_half,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  irq_pending,
  output logic             irq_n,
  output logic             wide_access_select,
  output logic      [1:0]  multi_level_priority_select,
  input  wire logic [7:0]  class_done,
  input  wire logic [31:0] class_result,
  input  wire logic [7:0]  class_clear,
  output logic      [7:0]  class_event_flag,
  input  wire logic [7:0]  detect_done,
  input  wire logic [31:0] detect_result,
  input  wire logic [7:0]  detect_clear,
  output logic      [7:0]  detect_event_flag,
  input  wire logic [7:0]  power_grant,
  input  wire logic [7:0]  current_limit_active,
  input  wire logic [7:0]  overload_active,
  input  wire logic [7:0]  four_pair,
  input  wire logic [7:0]  mps_present,
  input  wire logic [7:0]  startup_timeout,
  input  wire logic [7:0]  current_limit_timeout,
  input  wire logic [7:0]  overload_timeout,
  input  wire logic [1:0]  signature_dropout_timeout,
  output logic      [7:0]  power_good_flag,
  output logic      [7:0]  power_enable_flag
);

  localparam int NCH = pgcb_pkg::CHANNELS;
  localparam int MSW = pgcb_pkg::MS_W;
  localparam int RW  = pgcb_pkg::RESULT_W;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic int half_of(input int ch);
    return ch / pgcb_pkg::HALF_CHANNELS;
  endfunction

  function automatic logic [MSW-1:0] dropout_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    return pgcb_pkg::DROPOUT_SEL0_MS;
      2'h1:    return pgcb_pkg::DROPOUT_SEL1_MS;
      2'h2:    return pgcb_pkg::DROPOUT_SEL2_MS;
      default: return pgcb_pkg::DROPOUT_SEL3_MS;
    endcase
  endfunction

  function automatic logic [MSW-1:0] count_up(input logic [MSW-1:0] v);
    return (v == pgcb_pkg::MS_COUNT_MAX) ? v : MSW'(v + 1'b1);
  endfunction

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic        ms_tick;

  always_comb begin
    ms_tick       = (tick_cnt == 16'(TICK_CYCLES - 1));
    next_tick_cnt = ms_tick ? 16'h0000 : 16'(tick_cnt + 1'b1);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Configuration register, one copy per four-channel half
  // ---------------------------------------------------------------
  logic [7:0] cfg [2];
  logic [7:0] next_cfg [2];
  logic [7:0] next_rdata;
  logic       hit;
  logic       sel_half;
  logic [7:0] eff [2];

  always_comb begin
    hit      = (reg_cmd == pgcb_pkg::GLOBAL_EVENT_CONFIG);
    // Wide mode has one address, so the low copy answers for both
    sel_half = reg_half & ~cfg[0][pgcb_pkg::WIDE_ACCESS_SELECT_BIT];
    next_cfg = cfg;
    next_rdata = reg_rdata;
    if (reg_wr && hit) begin
      next_cfg[sel_half] = reg_wdata;
    end
    if (reg_rd) begin
      next_rdata = hit ? cfg[sel_half] : 8'h00;
    end
    // Wide mode lets the low copy govern all eight channels
    eff[0] = cfg[0];
    eff[1] = cfg[0][pgcb_pkg::WIDE_ACCESS_SELECT_BIT] ? cfg[0] : cfg[1];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg[0]    <= pgcb_pkg::GLOBAL_EVENT_RESET;
      cfg[1]    <= pgcb_pkg::GLOBAL_EVENT_RESET;
      reg_rdata <= 8'h00;
    end else begin
      cfg       <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt gate and mode outputs
  // ---------------------------------------------------------------
  logic next_irq_n;

  always_comb begin
    next_irq_n = ~((irq_pending[0] &
                    eff[0][pgcb_pkg::IRQ_OUTPUT_ENABLE_BIT]) |
                   (irq_pending[1] &
                    eff[1][pgcb_pkg::IRQ_OUTPUT_ENABLE_BIT]));
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_n                       <= 1'b1;
      wide_access_select          <= 1'b0;
      multi_level_priority_select <= 2'h0;
    end else begin
      irq_n <= next_irq_n;
      // Only the low copy matters; the high copy bit is ignored
      wide_access_select <=
        cfg[0][pgcb_pkg::WIDE_ACCESS_SELECT_BIT];
      multi_level_priority_select <=
        {eff[1][pgcb_pkg::MULTI_LEVEL_PRIORITY_BIT],
         eff[0][pgcb_pkg::MULTI_LEVEL_PRIORITY_BIT]};
    end
  end

  // ---------------------------------------------------------------
  // Detection and classification event flags
  // ---------------------------------------------------------------
  logic [RW-1:0] last_class [NCH];
  logic [RW-1:0] last_detect [NCH];
  logic [RW-1:0] next_last_class [NCH];
  logic [RW-1:0] next_last_detect [NCH];
  logic [7:0]    next_class_flag;
  logic [7:0]    next_detect_flag;
  logic [7:0]    class_set;
  logic [7:0]    detect_set;

  // Capture never looks at the interrupt enable bit
  always_comb begin
    next_last_class  = last_class;
    next_last_detect = last_detect;
    for (int ch = 0; ch < NCH; ch++) begin
      class_set[ch] = class_done[ch] &
        (~eff[half_of(ch)][pgcb_pkg::CLASS_CHANGE_ONLY_BIT] |
         (class_result[ch*RW +: RW] != last_class[ch]));
      detect_set[ch] = detect_done[ch] &
        (~eff[half_of(ch)][pgcb_pkg::DETECT_CHANGE_ONLY_BIT] |
         (detect_result[ch*RW +: RW] != last_detect[ch]));
      if (class_done[ch]) begin
        next_last_class[ch] = class_result[ch*RW +: RW];
      end
      if (detect_done[ch]) begin
        next_last_detect[ch] = detect_result[ch*RW +: RW];
      end
    end
    // A set in the clearing cycle survives
    next_class_flag  = (class_event_flag & ~class_clear) | class_set;
    next_detect_flag = (detect_event_flag & ~detect_clear) | detect_set;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      class_event_flag  <= 8'h00;
      detect_event_flag <= 8'h00;
      for (int ch = 0; ch < NCH; ch++) begin
        last_class[ch]  <= 4'h0;
        last_detect[ch] <= 4'h0;
      end
    end else begin
      class_event_flag  <= next_class_flag;
      detect_event_flag <= next_detect_flag;
      last_class        <= next_last_class;
      last_detect       <= next_last_detect;
    end
  end

  // ---------------------------------------------------------------
  // Fault timers and power status
  // ---------------------------------------------------------------
  logic [MSW-1:0] lim_cnt [NCH];
  logic [MSW-1:0] ovl_cnt [NCH];
  logic [MSW-1:0] dro_cnt [NCH];
  logic [MSW-1:0] next_lim_cnt [NCH];
  logic [MSW-1:0] next_ovl_cnt [NCH];
  logic [MSW-1:0] next_dro_cnt [NCH];
  logic [MSW-1:0] ovl_limit [NCH];
  logic [7:0]     fault;
  logic [7:0]     next_pg;
  logic [7:0]     next_pe;

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      ovl_limit[ch] = MSW'(overload_timeout) +
        (four_pair[ch] ? pgcb_pkg::FOUR_PAIR_EXTRA_MS : 10'h000);
      next_lim_cnt[ch] = !current_limit_active[ch] ? 10'h000 :
        (ms_tick ? count_up(lim_cnt[ch]) : lim_cnt[ch]);
      next_ovl_cnt[ch] = !overload_active[ch] ? 10'h000 :
        (ms_tick ? count_up(ovl_cnt[ch]) : ovl_cnt[ch]);
      // Reload while current is seen; count down only when powered
      if (!power_enable_flag[ch] || mps_present[ch]) begin
        next_dro_cnt[ch] = dropout_ms(signature_dropout_timeout);
      end else if (ms_tick && dro_cnt[ch] != 10'h000) begin
        next_dro_cnt[ch] = MSW'(dro_cnt[ch] - 1'b1);
      end else begin
        next_dro_cnt[ch] = dro_cnt[ch];
      end
      // Strict compare: a partial first tick never shortens the wait
      fault[ch] =
        (current_limit_active[ch] &&
         lim_cnt[ch] > MSW'(current_limit_timeout)) ||
        (overload_active[ch] && ovl_cnt[ch] > ovl_limit[ch]) ||
        (power_enable_flag[ch] && !mps_present[ch] &&
         dro_cnt[ch] == 10'h000) ||
        startup_timeout[ch];
    end
    // Fault beats a grant arriving in the same cycle
    next_pg = (power_good_flag | power_grant) & ~fault;
    next_pe = (power_enable_flag | power_grant) & ~fault;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_good_flag   <= 8'h00;
      power_enable_flag <= 8'h00;
      for (int ch = 0; ch < NCH; ch++) begin
        lim_cnt[ch] <= 10'h000;
        ovl_cnt[ch] <= 10'h000;
        dro_cnt[ch] <= pgcb_pkg::DROPOUT_SEL0_MS;
      end
    end else begin
      power_good_flag   <= next_pg;
      power_enable_flag <= next_pe;
      lim_cnt           <= next_lim_cnt;
      ovl_cnt           <= next_ovl_cnt;
      dro_cnt           <= next_dro_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_irq_gate_off: assert property (
    !eff[0][7] && !eff[1][7] |=> irq_n)
    else $error("interrupt output active while gated");
  a_irq_gate_on: assert property (
    irq_pending[0] && eff[0][7] |=> !irq_n)
    else $error("enabled pending interrupt not shown");
  a_cfg_write_read: assert property (
    reg_wr && hit && !sel_half ##1 !reg_wr ##1 reg_rd && hit && !sel_half
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("config byte not read back");
  a_wide_from_low: assert property (
    ##1 wide_access_select == $past(cfg[0][5]))
    else $error("wide access not taken from low copy");
  a_class_every: assert property (
    class_done[2] && !eff[0][3] |=> class_event_flag[2])
    else $error("class flag missed");
  a_class_same: assert property (
    class_done[2] && eff[0][3] && class_result[11:8] == last_class[2]
    && !class_event_flag[2] |=> !class_event_flag[2])
    else $error("class flag set without change");
  a_detect_change: assert property (
    detect_done[2] && detect_result[11:8] != last_detect[2]
    |=> detect_event_flag[2])
    else $error("detect change missed");
  a_fault_clears: assert property (
    startup_timeout[2] |=> !power_good_flag[2] && !power_enable_flag[2])
    else $error("power flags survive fault");
  a_dropout_floor: assert property (
    dro_cnt[2] == 10'h000 && power_enable_flag[2] && !mps_present[2]
    |=> dro_cnt[2] == 10'h000)
    else $error("dropout counter wrapped");
  a_limit_min: assert property (
    current_limit_active[2] && lim_cnt[2] <= 10'(current_limit_timeout)
    && !overload_active[2] && !startup_timeout[2] && mps_present[2]
    && power_good_flag[2] |=> power_good_flag[2])
    else $error("limit fault declared early");

  c_wide_mode: cover property (wide_access_select);
  c_class_change: cover property (class_done[2] ##1 class_event_flag[2]);
  c_dropout_fault: cover property (
    power_enable_flag[2] ##1 !power_enable_flag[2]);

endmodule // pgcb_config_bank

// ===== tb/pgcb_host_model.sv
// Host side of the configuration register port: byte writes and reads.
// Assumes requests start 1 ns after a rising edge of sys_clk.
`timescale 1ns/100ps

module pgcb_host_model #(
  parameter int QUIET_CYCLES = 5000
) (
  input  wire logic       sys_clk,
  output logic      [7:0] reg_cmd,
  output logic            reg_half,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  logic [7:0] shadow [2] = '{8'h80, 8'h80};

  initial begin
    reg_cmd   = 8'h00;
    reg_half  = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] cmd, input logic half,
                    input logic [7:0] data);
    // Shutdown input kept idle 200 us before priority goes multi-level
    if (cmd == 8'h17 && data[4] && !shadow[half][4])
      repeat (QUIET_CYCLES) @(posedge sys_clk);
    @(posedge sys_clk) #1;
    reg_cmd   = cmd;
    reg_half  = half;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr    = 1'b0;
    // Released data is inverted so stale bytes never look valid
    reg_wdata = ~data;
    if (cmd == 8'h17)
      shadow[half] = data;
  endtask

  task automatic rd(input logic [7:0] cmd, input logic half,
                    output logic [7:0] data);
    @(posedge sys_clk) #1;
    reg_cmd  = cmd;
    reg_half = half;
    reg_rd   = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd   = 1'b0;
    data     = reg_rdata;
  endtask
endmodule // pgcb_host_model

// ===== tb/pgcb_config_bank_test.sv
// Self-checking bench for the global event configuration bank.
// Assumes the host model on the register port and a 4-cycle ms tick.
`timescale 1ns/100ps

module pgcb_config_bank_test;
  localparam int         TICK = 4;
  localparam logic [7:0] CFG  = 8'h17;
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic [7:0]  reg_cmd, reg_wdata, reg_rdata, rd_val;
  logic        reg_half, reg_wr, reg_rd, irq_n, wide;
  logic [1:0]  irq_pending = 2'b00;
  logic [1:0]  prio;
  logic [1:0]  drop_sel    = 2'b00;
  logic [7:0]  cls_done = 8'h00, cls_clr = 8'h00, cls_flag;
  logic [7:0]  det_done = 8'h00, det_clr = 8'h00, det_flag;
  logic [31:0] cls_res  = 32'h0, det_res = 32'h0;
  logic [7:0]  grant = 8'h00, lim = 8'h00, ovl = 8'h00, quad = 8'h00;
  logic [7:0]  mps = 8'hff, stmo = 8'h00, pg, pe;
  logic [7:0]  lim_to = 8'h02, ovl_to = 8'h01;
  int          ms [4]      = '{360, 90, 180, 720};
  int          error_cnt   = 0;
  int          checks_done = 0;

  always #20 sys_clk = ~sys_clk;

  pgcb_host_model host (
    .sys_clk(sys_clk), .reg_cmd(reg_cmd), .reg_half(reg_half),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  pgcb_config_bank #(.TICK_CYCLES(TICK)) dut (
    .sys_clk(sys_clk), .reset(reset), .reg_cmd(reg_cmd),
    .reg_half(reg_half), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_pending(irq_pending), .irq_n(irq_n), .wide_access_select(wide),
    .multi_level_priority_select(prio), .class_done(cls_done),
    .class_result(cls_res), .class_clear(cls_clr),
    .class_event_flag(cls_flag), .detect_done(det_done),
    .detect_result(det_res), .detect_clear(det_clr),
    .detect_event_flag(det_flag), .power_grant(grant),
    .current_limit_active(lim), .overload_active(ovl), .four_pair(quad),
    .mps_present(mps), .startup_timeout(stmo),
    .current_limit_timeout(lim_to), .overload_timeout(ovl_to),
    .signature_dropout_timeout(drop_sel), .power_good_flag(pg),
    .power_enable_flag(pe));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic flag(input logic cls);
    return cls ? cls_flag[2] : det_flag[2];
  endfunction

  task automatic pulse(input logic cls, input logic [3:0] r);
    if (cls) begin
      cls_res[11:8] = r;
      cls_done[2]   = 1'b1;
    end else begin
      det_res[11:8] = r;
      det_done[2]   = 1'b1;
    end
    step(1);
    cls_done = 8'h00;
    det_done = 8'h00;
  endtask

  task automatic clear_flags;
    cls_clr = 8'hff;
    det_clr = 8'hff;
    step(1);
    cls_clr = 8'h00;
    det_clr = 8'h00;
  endtask

  task automatic power_on;
    grant[2] = 1'b1;
    step(1);
    grant[2] = 1'b0;
    check("powered", 2'b11, {pg[2], pe[2]});
  endtask

  // Counts cycles until power good drops, bounded by hi
  task automatic wait_drop(input string what, input int lo, input int hi);
    int n;
    n = 0;
    while (pg[2] === 1'b1 && n < hi) begin
      step(1);
      n++;
    end
    check(what, 1'b1, (n >= lo && n < hi));
    check("enable cut", 1'b0, pe[2]);
    if (n >= hi)
      complete_run();
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_registers;
    host.rd(CFG, 1'b0, rd_val);
    check("reset low copy", 8'h80, rd_val);
    check("irq_n idle", 1'b1, irq_n);
    check("wide at reset", 1'b0, wide);
    host.wr(CFG, 1'b1, 8'hc3);
    host.rd(CFG, 1'b1, rd_val);
    check("loose bits", 8'hc3, rd_val);
    host.wr(8'h16, 1'b1, 8'h00);
    host.rd(CFG, 1'b1, rd_val);
    check("foreign write", 8'hc3, rd_val);
    host.rd(8'h16, 1'b1, rd_val);
    check("foreign read", 8'h00, rd_val);
  endtask

  task automatic test_irq;
    irq_pending = 2'b01;
    step(2);
    check("irq_n low half", 1'b0, irq_n);
    irq_pending = 2'b10;
    step(2);
    check("irq_n enabled", 1'b0, irq_n);
    host.wr(CFG, 1'b0, 8'h00);
    host.rd(CFG, 1'b0, rd_val);
    check("low copy write", 8'h00, rd_val);
    check("irq_n high copy", 1'b0, irq_n);
    host.wr(CFG, 1'b1, 8'h00);
    step(2);
    check("irq_n masked", 1'b1, irq_n);
    irq_pending = 2'b00;
  endtask

  task automatic test_access;
    host.wr(CFG, 1'b1, 8'h30);
    step(1);
    check("wide from high", 1'b0, wide);
    check("prio split", 2'b10, prio);
    host.wr(CFG, 1'b0, 8'h20);
    step(1);
    check("wide from low", 1'b1, wide);
    check("prio follows low", 2'b00, prio);
    host.rd(CFG, 1'b1, rd_val);
    check("wide read", 8'h20, rd_val);
    host.wr(CFG, 1'b1, 8'h00);
    step(1);
    check("wide write", 1'b0, wide);
    check("prio back", 2'b10, prio);
  endtask

  task automatic test_policy(input logic cls, input logic [7:0] chg);
    host.wr(CFG, 1'b0, 8'h00);
    clear_flags();
    pulse(cls, 4'h5);
    check("every cycle", 1'b1, flag(cls));
    clear_flags();
    pulse(cls, 4'h5);
    check("every repeat", 1'b1, flag(cls));
    clear_flags();
    host.wr(CFG, 1'b0, chg);
    pulse(cls, 4'h5);
    check("same result", 1'b0, flag(cls));
    pulse(cls, 4'h9);
    check("changed result", 1'b1, flag(cls));
  endtask

  task automatic test_power;
    power_on();
    stmo[2] = 1'b1;
    step(1);
    stmo[2] = 1'b0;
    check("startup cut", 2'b00, {pg[2], pe[2]});
    power_on();
    lim[2] = 1'b1;
    wait_drop("limit", lim_to * TICK, (lim_to + 2) * TICK + 2);
    lim[2] = 1'b0;
    power_on();
    ovl[2]  = 1'b1;
    wait_drop("pair overload", ovl_to * TICK,
              (ovl_to + 2) * TICK + 2);
    ovl[2]  = 1'b0;
    power_on();
    quad[2] = 1'b1;
    ovl[2]  = 1'b1;
    wait_drop("quad overload", (ovl_to + 6) * TICK,
              (ovl_to + 8) * TICK + 2);
    ovl[2]  = 1'b0;
    for (int s = 0; s < 4; s++) begin
      drop_sel = s[1:0];
      power_on();
      mps[2] = 1'b0;
      wait_drop("dropout", (ms[s] - 1) * TICK,
                (ms[s] + 2) * TICK);
      mps[2] = 1'b1;
    end
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    #1 reset = 1'b0;
    test_registers();
    test_irq();
    test_access();
    test_policy(1'b1, 8'h08);
    test_policy(1'b0, 8'h04);
    test_power();
    complete_run();
  end
endmodule // pgcb_config_bank_test
